// ### hw/dms_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "dms_defines.svh"
module dms_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // link
  dms_if.ctrl lnk,
  // user side
  output logic busy,
  output logic loop_on,
  output logic rd_strobe,
  output logic [7:0] rd_data
);
  typedef struct packed {
    logic av_wait;
    logic [31:0] rdata;
    dms_pkg::dms_ctrl_state_t state;
    dms_pkg::dms_ctrl_state_t ret;
    logic [8:0] cnt;
    logic path_off;
    logic abort_en;
    logic [4:0] rl_on;
    logic [4:0] wl_on;
    logic loop_on;
    logic busy;
    dms_pkg::dms_cmd_t k;
    logic freq_low;
    logic strobe;
    logic [7:0] data;
  } dms_ctrl_st_t;

  dms_ctrl_st_t st;
  dms_ctrl_st_t next_st;
  logic req;

  function automatic dms_pkg::dms_cmd_t mk(input logic [2:0] op, input logic [2:0] sel,
                                           input logic [13:0] a);
    dms_pkg::dms_cmd_t c;
    c.cke = 1'b1;
    c.cs_n = 1'b0;
    c.act_line_low = 1'b1;
    c.op = op;
    c.bg = {1'b0, sel[2]};
    c.ba = sel[1:0];
    c.a = a;
    c.term_ctl = 1'b0;
    return c;
  endfunction

  always_comb
  begin
    next_st = st;
    req = avs_read || avs_write;
    // deselect on every idle or waiting edge, clock enable kept
    next_st.k = mk(3'h7, 3'h0, 14'h0000);
    next_st.k.cs_n = 1'b1;
    next_st.k.cke = st.k.cke;
    next_st.k.term_ctl = 1'b0;
    // read capture aligned by the link strobe, not by latency count
    next_st.strobe = lnk.strobe;
    if (lnk.strobe)
      next_st.data = lnk.dq;
    next_st.av_wait = !(req && st.av_wait);
    if (req && st.av_wait)
    begin
      case (avs_address)
        `DMS_REG_CTRL: next_st.rdata = {11'h000, st.wl_on, 3'h0, st.rl_on, 4'h0, st.abort_en, 3'h0};
        `DMS_REG_STAT: next_st.rdata = {24'h000000, st.state, 1'b0, st.freq_low, st.loop_on, st.busy};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
    if (avs_write && !st.av_wait && avs_address == `DMS_REG_CTRL && st.state == dms_pkg::C_IDLE)
    begin
      next_st.abort_en = avs_writedata[`DMS_CTRL_ABORT];
      next_st.rl_on = avs_writedata[`DMS_CTRL_RL_LSB +: 5];
      next_st.wl_on = avs_writedata[`DMS_CTRL_WL_LSB +: 5];
      if (avs_writedata[`DMS_CTRL_GO_OFF] && st.loop_on)
      begin
        next_st.path_off = 1'b1;
        next_st.state = dms_pkg::C_PREA;
      end
      else if (avs_writedata[`DMS_CTRL_GO_ON] && !st.loop_on)
      begin
        next_st.path_off = 1'b0;
        next_st.state = dms_pkg::C_PREA;
      end
    end
    case (st.state)
      dms_pkg::C_IDLE: ;
      dms_pkg::C_PREA:
      begin
        // closing every bank gives the idle state self refresh needs
        next_st.k = mk(`DMS_OP_PRE, 3'h0, 14'(1 << `DMS_PREA_BIT));
        next_st.cnt = 9'(`DMS_C_RP);
        next_st.ret = dms_pkg::C_ABORT_SET;
        next_st.state = dms_pkg::C_WAIT;
      end
      dms_pkg::C_ABORT_SET:
      begin
        next_st.k = mk(`DMS_OP_MRS, `DMS_SEL_MODE_FOUR, 14'({st.abort_en, 9'h000}));
        next_st.cnt = 9'(`DMS_C_MRD);
        next_st.ret = dms_pkg::C_TERM;
        next_st.state = dms_pkg::C_WAIT;
      end
      dms_pkg::C_TERM:
      begin
        // nominal termination to high-impedance before any loop change
        next_st.k = mk(`DMS_OP_MRS, `DMS_SEL_MODE_ONE, {13'h0000, st.loop_on});
        next_st.cnt = 9'(`DMS_C_MOD);
        next_st.ret = st.path_off ? dms_pkg::C_LOOP_OFF : dms_pkg::C_SRE;
        next_st.state = dms_pkg::C_WAIT;
      end
      dms_pkg::C_LOOP_OFF:
      begin
        next_st.k = mk(`DMS_OP_MRS, `DMS_SEL_MODE_ONE, 14'h0000);
        next_st.loop_on = 1'b0;
        next_st.cnt = 9'(`DMS_C_MOD);
        next_st.ret = dms_pkg::C_SRE;
        next_st.state = dms_pkg::C_WAIT;
      end
      dms_pkg::C_SRE:
      begin
        next_st.k = mk(`DMS_OP_REF, 3'h0, 14'h0000);
        next_st.k.cke = 1'b0;
        next_st.cnt = 9'(`DMS_C_CKSRE);
        next_st.ret = dms_pkg::C_FREQ;
        next_st.state = dms_pkg::C_WAIT;
      end
      dms_pkg::C_FREQ:
      begin
        // clock rate only moves inside self refresh
        next_st.freq_low = st.path_off;
        next_st.cnt = 9'(`DMS_C_CKSRX);
        next_st.ret = dms_pkg::C_SRX;
        next_st.state = dms_pkg::C_WAIT;
      end
      dms_pkg::C_SRX:
      begin
        next_st.k.cke = 1'b1;
        // abort-enabled exit waits the shorter abort delay, otherwise the full exit delay
        next_st.cnt = st.abort_en ? 9'(`DMS_C_XS_ABORT) : 9'(`DMS_C_XS);
        next_st.ret = st.path_off ? dms_pkg::C_RL : dms_pkg::C_LOOP_ON;
        next_st.state = dms_pkg::C_WAIT;
      end
      dms_pkg::C_LOOP_ON:
      begin
        next_st.k = mk(`DMS_OP_MRS, `DMS_SEL_MODE_ONE, 14'h0001);
        next_st.loop_on = 1'b1;
        next_st.cnt = 9'(`DMS_C_MRD);
        next_st.ret = dms_pkg::C_RL;
        next_st.state = dms_pkg::C_WAIT;
      end
      dms_pkg::C_RL:
      begin
        if (st.path_off)
          next_st.k = mk(`DMS_OP_MRS, `DMS_SEL_MODE_ZERO, 14'({`DMS_OFF_RL, 2'h0}));
        else
          next_st.k = mk(`DMS_OP_MRS, `DMS_SEL_MODE_ZERO, 14'({1'b1, 1'b0, st.rl_on, 2'h0}));
        next_st.cnt = 9'(`DMS_C_MRD);
        next_st.ret = dms_pkg::C_WL;
        next_st.state = dms_pkg::C_WAIT;
      end
      dms_pkg::C_WL:
      begin
        next_st.k = mk(`DMS_OP_MRS, `DMS_SEL_MODE_TWO, 14'({st.path_off ? `DMS_OFF_WL : st.wl_on, 3'h0}));
        // lock time counted from here outlasts it from the loop reset
        next_st.cnt = st.path_off ? 9'(`DMS_C_MOD) : 9'(`DMS_C_DLLK);
        next_st.ret = dms_pkg::C_REF;
        next_st.state = dms_pkg::C_WAIT;
      end
      dms_pkg::C_REF:
      begin
        next_st.k = mk(`DMS_OP_REF, 3'h0, 14'h0000);
        next_st.cnt = 9'(`DMS_C_RFC);
        next_st.ret = dms_pkg::C_IDLE;
        next_st.state = dms_pkg::C_WAIT;
      end
      dms_pkg::C_WAIT:
      begin
        next_st.cnt = st.cnt - 9'h001;
        if (st.cnt == 9'h001)
          next_st.state = st.ret;
      end
      default: next_st.state = dms_pkg::C_IDLE;
    endcase
    next_st.busy = next_st.state != dms_pkg::C_IDLE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.av_wait <= 1'b1;
      st.loop_on <= 1'b1;
      st.state <= dms_pkg::C_IDLE;
      st.ret <= dms_pkg::C_IDLE;
      st.rl_on <= `DMS_OFF_RL;
      st.wl_on <= `DMS_OFF_WL;
      st.k <= '1;
      st.k.op <= 3'h7;
      st.k.term_ctl <= 1'b0;
    end
    else
      st <= next_st;
  end

  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.av_wait;
  assign busy = st.busy;
  assign loop_on = st.loop_on;
  assign rd_strobe = st.strobe;
  assign rd_data = st.data;
  assign lnk.cke = st.k.cke;
  assign lnk.cs_n = st.k.cs_n;
  assign lnk.activate_line_low = st.k.act_line_low;
  assign lnk.ras_n = st.k.op[2];
  assign lnk.cas_n = st.k.op[1];
  assign lnk.we_n = st.k.op[0];
  assign lnk.bg = st.k.bg;
  assign lnk.ba = st.k.ba;
  assign lnk.a = st.k.a;
  assign lnk.termination_control = st.k.term_ctl;
  assign lnk.freq_low = st.freq_low;
endmodule
`default_nettype wire

// ### hw/dms_defines.svh
`ifndef DMS_DEFINES_SVH
`define DMS_DEFINES_SVH
`define DMS_CLK_NS 50
`define DMS_CEIL(ns) (((ns) + `DMS_CLK_NS - 1) / `DMS_CLK_NS)
`define DMS_T_MOD_NS 600
`define DMS_T_MRD_NS 400
`define DMS_T_RP_NS 300
`define DMS_T_RFC_NS 1000
`define DMS_T_CKSRE_NS 500
`define DMS_T_CKSRX_NS 500
`define DMS_T_XS_NS 1000
`define DMS_T_XS_ABORT_NS 700
`define DMS_T_DLLK_NS 20000
`define DMS_C_MOD `DMS_CEIL(`DMS_T_MOD_NS)
`define DMS_C_MRD `DMS_CEIL(`DMS_T_MRD_NS)
`define DMS_C_RP `DMS_CEIL(`DMS_T_RP_NS)
`define DMS_C_RFC `DMS_CEIL(`DMS_T_RFC_NS)
`define DMS_C_CKSRE `DMS_CEIL(`DMS_T_CKSRE_NS)
`define DMS_C_CKSRX `DMS_CEIL(`DMS_T_CKSRX_NS)
`define DMS_C_XS `DMS_CEIL(`DMS_T_XS_NS)
`define DMS_C_XS_ABORT `DMS_CEIL(`DMS_T_XS_ABORT_NS)
`define DMS_C_DLLK `DMS_CEIL(`DMS_T_DLLK_NS)
`define DMS_OP_MRS 3'h0
`define DMS_OP_REF 3'h1
`define DMS_OP_PRE 3'h2
`define DMS_OP_RD 3'h5
`define DMS_SEL_MODE_ZERO 3'h0
`define DMS_SEL_MODE_ONE 3'h1
`define DMS_SEL_MODE_TWO 3'h2
`define DMS_SEL_MODE_FOUR 3'h4
`define DMS_RL_FIELD_LSB 2
`define DMS_LOOP_RST_BIT 8
`define DMS_LOOP_EN_BIT 0
`define DMS_ADD_LAT_LSB 3
`define DMS_TERM_FIELD_LSB 8
`define DMS_WL_FIELD_LSB 3
`define DMS_ABORT_BIT 9
`define DMS_PREA_BIT 10
`define DMS_OFF_RL 5'h0A
`define DMS_OFF_WL 5'h09
`define DMS_REG_CTRL 2'h0
`define DMS_REG_STAT 2'h1
`define DMS_CTRL_GO_OFF 0
`define DMS_CTRL_GO_ON 1
`define DMS_CTRL_ABORT 3
`define DMS_CTRL_RL_LSB 8
`define DMS_CTRL_WL_LSB 16
`endif

// ### hw/dms_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "dms_defines.svh"
module dms_device (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // link
  dms_if.dev lnk,
  // user side
  input wire logic [7:0] rd_word,
  output logic loop_on,
  output logic loop_locked,
  output logic in_self_refresh,
  output logic cmd_ready,
  output logic [7:0] refresh_count,
  output logic [4:0] read_latency,
  output logic [4:0] write_latency
);
  typedef struct packed {
    logic cke_q;
    logic sr;
    logic loop_en;
    logic locked;
    logic abort_en;
    logic ready;
    logic [1:0] add_lat_sel;
    logic [2:0] rtt;
    logic [4:0] rl;
    logic [4:0] wl;
    logic [8:0] ref_busy;
    logic [7:0] ref_cnt;
    logic [8:0] xs_cnt;
    logic [8:0] lock_cnt;
    logic [5:0] rd_cnt;
    logic strobe;
    logic [7:0] dq;
  } dms_dev_st_t;

  dms_dev_st_t st;
  dms_dev_st_t next_st;
  logic cmd_ok;
  logic [5:0] add_lat;
  logic [2:0] sel;

  always_comb
  begin
    next_st = st;
    next_st.cke_q = lnk.cke;
    next_st.strobe = 1'b0;
    sel = {lnk.bg[0], lnk.ba};
    add_lat = (st.add_lat_sel == 2'h0) ? 6'h00 : {1'b0, st.rl} - {4'h0, st.add_lat_sel};
    // deselect and no-operation both fall through without effect
    cmd_ok = st.cke_q && lnk.cke && !lnk.cs_n && !st.sr;
    // running refresh and reads count down; a new one restarts them, an abort-enabled exit drops the refresh
    if (st.ref_busy != 9'h000)
    begin
      next_st.ref_busy = st.ref_busy - 9'h001;
      if (st.ref_busy == 9'h001)
        next_st.ref_cnt = st.ref_cnt + 8'h01;
    end
    if (st.sr && st.ref_busy == 9'h000)
      next_st.ref_busy = 9'(`DMS_C_RFC);
    if (st.xs_cnt != 9'h000)
      next_st.xs_cnt = st.xs_cnt - 9'h001;
    next_st.ready = (next_st.xs_cnt == 9'h000) && !next_st.sr;
    if (st.lock_cnt != 9'h000)
    begin
      next_st.lock_cnt = st.lock_cnt - 9'h001;
      next_st.locked = (st.lock_cnt == 9'h001) && st.loop_en;
    end
    if (st.rd_cnt != 6'h00)
    begin
      next_st.rd_cnt = st.rd_cnt - 6'h01;
      if (st.rd_cnt == 6'h01)
      begin
        // strobe and data leave together in both loop modes
        next_st.strobe = 1'b1;
        next_st.dq = rd_word;
      end
    end
    if (!st.sr && st.cke_q && !lnk.cke && !lnk.cs_n && lnk.activate_line_low
        && {lnk.ras_n, lnk.cas_n, lnk.we_n} == `DMS_OP_REF)
    begin
      next_st.sr = 1'b1;
      next_st.ready = 1'b0;
    end
    if (st.sr && !st.cke_q && lnk.cke && lnk.cs_n)
    begin
      next_st.sr = 1'b0;
      next_st.ready = 1'b0;
      if (st.abort_en)
      begin
        next_st.ref_busy = 9'h000;
        next_st.xs_cnt = 9'(`DMS_C_XS_ABORT);
      end
      else
        next_st.xs_cnt = 9'(`DMS_C_XS);
    end
    if (cmd_ok && lnk.activate_line_low)
    begin
      case ({lnk.ras_n, lnk.cas_n, lnk.we_n})
        `DMS_OP_MRS:
        begin
          case (sel)
            `DMS_SEL_MODE_ZERO:
            begin
              next_st.rl = lnk.a[`DMS_RL_FIELD_LSB +: 5];
              if (lnk.a[`DMS_LOOP_RST_BIT] && st.loop_en)
              begin
                next_st.lock_cnt = 9'(`DMS_C_DLLK);
                next_st.locked = 1'b0;
              end
            end
            `DMS_SEL_MODE_ONE:
            begin
              next_st.loop_en = lnk.a[`DMS_LOOP_EN_BIT];
              if (!lnk.a[`DMS_LOOP_EN_BIT])
              begin
                next_st.locked = 1'b0;
                next_st.lock_cnt = 9'h000;
              end
              next_st.add_lat_sel = lnk.a[`DMS_ADD_LAT_LSB +: 2];
              next_st.rtt = lnk.a[`DMS_TERM_FIELD_LSB +: 3];
            end
            `DMS_SEL_MODE_TWO: next_st.wl = lnk.a[`DMS_WL_FIELD_LSB +: 5];
            `DMS_SEL_MODE_FOUR: next_st.abort_en = lnk.a[`DMS_ABORT_BIT];
            default: ;
          endcase
        end
        `DMS_OP_REF: next_st.ref_busy = 9'(`DMS_C_RFC);
        `DMS_OP_RD:
        begin
          // loop off starts the strobe one cycle earlier
          if (st.loop_en)
            next_st.rd_cnt = add_lat + {1'b0, st.rl};
          else
            next_st.rd_cnt = add_lat + {1'b0, st.rl} - 6'h01;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.loop_en <= 1'b1;
      st.locked <= 1'b1;
      st.ready <= 1'b1;
      st.rl <= `DMS_OFF_RL;
      st.wl <= `DMS_OFF_WL;
    end
    else
      st <= next_st;
  end

  assign lnk.strobe = st.strobe;
  assign lnk.dq = st.dq;
  assign loop_on = st.loop_en;
  assign loop_locked = st.locked;
  assign in_self_refresh = st.sr;
  assign cmd_ready = st.ready;
  assign refresh_count = st.ref_cnt;
  assign read_latency = st.rl;
  assign write_latency = st.wl;
endmodule
`default_nettype wire

// ### hw/dms_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dms_if;
  logic cke;
  logic cs_n;
  logic activate_line_low;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] bg;
  logic [1:0] ba;
  logic [13:0] a;
  logic termination_control;
  logic freq_low;
  logic strobe;
  logic [7:0] dq;

  modport ctrl (
    output cke, cs_n, activate_line_low, ras_n, cas_n, we_n, bg, ba, a,
    output termination_control, freq_low,
    input strobe, dq
  );
  modport dev (
    input cke, cs_n, activate_line_low, ras_n, cas_n, we_n, bg, ba, a,
    input termination_control, freq_low,
    output strobe, dq
  );
endinterface
`default_nettype wire

// ### hw/dms_pkg.sv
`default_nettype none
package dms_pkg;
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic act_line_low;
    logic [2:0] op;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [13:0] a;
    logic term_ctl;
  } dms_cmd_t;

  typedef enum logic [3:0] {
    C_IDLE, C_PREA, C_ABORT_SET, C_TERM, C_LOOP_OFF, C_SRE, C_FREQ, C_SRX,
    C_LOOP_ON, C_RL, C_WL, C_REF, C_WAIT
  } dms_ctrl_state_t;
endpackage
`default_nettype wire

// ### testbench/dms_properties.sv
`timescale 1ns/10ps
`default_nettype none
module dms_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // link as seen on the wire
  input wire logic cke,
  input wire logic cs_n,
  input wire logic activate_line_low,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [13:0] a,
  input wire logic termination_control,
  input wire logic freq_low
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic prev_cke;
  logic need_ref;
  wire logic cmd = cke && !cs_n && activate_line_low;
  wire logic mrs = cmd && !ras_n && !cas_n && !we_n;
  wire logic [2:0] sel = {bg[0], ba};
  wire logic loop_en_write = mrs && sel == 3'h1 && a[0];
  // a refresh is owed after every exit; only a plain refresh pays it
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      prev_cke <= 1'b1;
      need_ref <= 1'b0;
    end
    else
    begin
      prev_cke <= cke;
      if (cke && !prev_cke)
        need_ref <= 1'b1;
      else if (cmd && prev_cke && !ras_n && !cas_n && we_n)
        need_ref <= 1'b0;
    end
  end
  sequence sr_cmd;
    !cs_n && activate_line_low && !ras_n && !cas_n && we_n;
  endsequence
  // shortest exit delay still has fourteen quiet edges
  sequence exit_quiet;
    (cke && cs_n) [*8] ##1 (cke && cs_n) [*6];
  endsequence
  a_no_nop_code: assert property (!(cmd && ras_n && cas_n && we_n))
    else $error("no-operation code on the link");
  a_sr_entry_form: assert property ($fell(cke) |-> sr_cmd)
    else $error("clock enable fell without entry command");
  a_sr_hold: assert property ($fell(cke) |=> (!cke && cs_n) [*8] ##1 (!cke && cs_n) [*2])
    else $error("self refresh left too early");
  a_exit_quiet: assert property ($rose(cke) |-> exit_quiet)
    else $error("command or clock enable drop during exit delay");
  a_freq_in_sr: assert property ($changed(freq_low) |-> !cke && !$past(cke, 10))
    else $error("frequency changed outside settled self refresh");
  a_clk_stable_exit: assert property ($rose(cke) |-> $past(freq_low, 10) == freq_low)
    else $error("clock not stable before exit");
  a_off_latency: assert property (mrs && freq_low |-> (sel != 3'h0 || a[6:2] == 5'h0A)
    && (sel != 3'h2 || a[7:3] == 5'h09))
    else $error("slow clock latency not 10 and 9");
  a_reset_after_on: assert property (mrs && sel == 3'h0 && a[8] |-> $past(loop_en_write, 9))
    else $error("loop reset not spaced after loop enable");
  a_mrs_spacing: assert property (mrs |=> cs_n [*8])
    else $error("command too soon after mode write");
  a_ref_before_sre: assert property ($fell(cke) |-> !need_ref)
    else $error("self refresh again without refresh");
  a_term_low: assert property (!termination_control)
    else $error("termination control raised");
endmodule
`default_nettype wire

// ### testbench/test_dll_mode_switch_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module test_dll_mode_switch_sequencer;
  logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, busy, loop_on;
  logic [1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] rd_word, rc, rc2, rdd1;
  logic dev_loop, locked, lp2, ready2, ab, sr1, rdy1, rs1;
  logic [4:0] rl, wl, r, w;
  int n_fail = 0, tests_run = 0, cyc = 0, seed, k;
  dms_if lnk();
  dms_if lnk2();
  dms_ctrl dms_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lnk(lnk), .busy(busy), .loop_on(loop_on), .rd_strobe(rs1), .rd_data(rdd1));
  dms_device dms_device_inst (.sys_clk(sys_clk), .rst_n(rst_n), .lnk(lnk), .rd_word(rd_word),
    .loop_on(dev_loop), .loop_locked(locked), .in_self_refresh(sr1), .cmd_ready(rdy1), .refresh_count(),
    .read_latency(rl), .write_latency(wl));
  // second device on a bench-driven link, for the device-side rules
  dms_device dms_device_inst2 (.sys_clk(sys_clk), .rst_n(rst_n), .lnk(lnk2), .rd_word(rd_word),
    .loop_on(lp2), .loop_locked(), .in_self_refresh(), .cmd_ready(ready2), .refresh_count(rc2),
    .read_latency(), .write_latency());
  dms_properties dms_properties_inst (.sys_clk(sys_clk), .rst_n(rst_n), .cke(lnk.cke), .cs_n(lnk.cs_n),
    .activate_line_low(lnk.activate_line_low), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n),
    .bg(lnk.bg), .ba(lnk.ba), .a(lnk.a), .termination_control(lnk.termination_control),
    .freq_low(lnk.freq_low));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask
  function automatic logic [31:0] ctrl_w(input logic b, input logic [4:0] rr, input logic [4:0] ww);
    return {11'h0, ww, 3'h0, rr, 4'h0, b, 3'h0};
  endfunction
  function automatic logic [31:0] stat_w(input logic lp, input logic fl);
    return {29'h0, fl, lp, 1'b0};
  endfunction
  function automatic int rd_edges(input int rlat, input logic on);
    return rlat - (on ? 0 : 1);
  endfunction
  task automatic av(input logic wr, input logic [1:0] adr, input logic [31:0] wd, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one wait cycle: answer sampled at the second edge
    chk("answer", 32'h2, k);
  endtask
  task automatic wait_idle();
    repeat (3) @(posedge sys_clk);
    k = 0;
    while (busy !== 1'b0 && k < 1500)
    begin
      @(posedge sys_clk);
      k++;
    end
    chk("busy", 0, {31'h0, busy});
  endtask
  // codes are {cs_n, ras, cas, we}; released lines show the inverse
  task automatic send(input logic ck, input logic [3:0] c, input logic [2:0] sel, input logic [13:0] ad);
    @(posedge sys_clk);
    lnk2.cke <= ck;
    lnk2.cs_n <= c[3];
    {lnk2.ras_n, lnk2.cas_n, lnk2.we_n} <= c[2:0];
    {lnk2.bg, lnk2.ba} <= {1'b0, sel};
    lnk2.a <= ad;
    @(posedge sys_clk);
    lnk2.cs_n <= 1'b1;
    {lnk2.ras_n, lnk2.cas_n, lnk2.we_n} <= ~c[2:0];
    lnk2.a <= ~ad;
  endtask
  // a deselected read right behind the real one must not disturb it
  task automatic rd_lat(input int e);
    rd_word <= 8'($random(seed));
    send(1'b1, 4'h5, 3'h0, 14'h0);
    send(1'b1, 4'hD, 3'h0, 14'h0);
    k = 0;
    while (lnk2.strobe !== 1'b1 && k < 40)
    begin
      @(posedge sys_clk);
      k++;
    end
    chk("read latency", e - 1, k);
    chk("read data", {24'h0, rd_word}, {24'h0, lnk2.dq});
  endtask
  task automatic sr_test(input logic b);
    send(1'b1, 4'h0, 3'h4, {4'h0, b, 9'h0});
    repeat (14) @(posedge sys_clk);
    rc = rc2;
    send(1'b0, 4'h1, 3'h0, 14'h0);
    repeat (12) @(posedge sys_clk);
    lnk2.cke <= 1'b1;
    repeat (18) @(posedge sys_clk);
    chk("exit ready", {31'h0, b}, {31'h0, ready2});
    repeat (8) @(posedge sys_clk);
    chk("refresh count", {24'h0, rc + {7'h0, !b}}, {24'h0, rc2});
    send(1'b1, 4'h1, 3'h0, 14'h0);
    repeat (22) @(posedge sys_clk);
  endtask
  initial
  begin
    seed = 32'h0748FE18;
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, rd_word} = '0;
    {lnk2.cke, lnk2.cs_n, lnk2.activate_line_low, lnk2.ras_n, lnk2.cas_n, lnk2.we_n} = 6'h3F;
    {lnk2.bg, lnk2.ba, lnk2.a, lnk2.termination_control, lnk2.freq_low} = '0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    av(1'b0, 2'h1, 32'h0, rd);
    chk("status", stat_w(1'b1, 1'b0), rd);
    av(1'b0, 2'h0, 32'h0, rd);
    chk("ctrl", ctrl_w(1'b0, 5'h0A, 5'h09), rd);
    av(1'b1, 2'h2, 32'hFFFFFFFF, rd);
    av(1'b0, 2'h3, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 2; i++)
    begin
      ab = i[0];
      r = 5'h09 + {2'h0, 3'($random(seed))};
      w = 5'h09 + {3'h0, 2'($random(seed))};
      av(1'b1, 2'h0, ctrl_w(ab, r, w) | 32'h1, rd);
      av(1'b1, 2'h0, 32'h2, rd);
      wait_idle();
      av(1'b0, 2'h1, 32'h0, rd);
      chk("status off", stat_w(1'b0, 1'b1), rd);
      av(1'b0, 2'h0, 32'h0, rd);
      chk("ctrl kept", ctrl_w(ab, r, w), rd);
      chk("device loop", 0, {31'h0, dev_loop});
      chk("off latencies", {22'h0, 5'h0A, 5'h09}, {22'h0, rl, wl});
      av(1'b1, 2'h0, ctrl_w(ab, r, w) | 32'h1, rd);
      repeat (3) @(posedge sys_clk);
      chk("refused", 0, {31'h0, busy});
      av(1'b1, 2'h0, ctrl_w(ab, r, w) | 32'h2, rd);
      wait_idle();
      av(1'b0, 2'h1, 32'h0, rd);
      chk("status on", stat_w(1'b1, 1'b0), rd);
      chk("device on", 2'h3, {30'h0, dev_loop, locked});
      chk("on latencies", {22'h0, r, w}, {22'h0, rl, wl});
      chk("device ready", 32'h1, {30'h0, sr1, rdy1});
    end
    chk("no capture", 32'h0, {23'h0, rs1, rdd1});
    rd_lat(rd_edges(10, 1'b1));
    send(1'b1, 4'h0, 3'h1, 14'h0);
    repeat (14) @(posedge sys_clk);
    chk("loop off", 0, {31'h0, lp2});
    rd_lat(rd_edges(10, 1'b0));
    send(1'b1, 4'h7, 3'h0, 14'h0);
    send(1'b1, 4'hD, 3'h0, 14'h0);
    k = 0;
    repeat (25)
    begin
      @(posedge sys_clk);
      if (lnk2.strobe === 1'b1)
        k++;
    end
    chk("stray strobe", 0, k);
    send(1'b1, 4'h0, 3'h1, 14'h1);
    repeat (14) @(posedge sys_clk);
    chk("loop on", 1, {31'h0, lp2});
    sr_test(1'b1);
    sr_test(1'b0);
    close_out();
  end
endmodule
`default_nettype wire
